// [hdl/dac_pkg.sv]
// Summary of operation
// - input word is ten bits, bit 9 most significant, bit 0 least.
// - each sample-clock edge updates both outputs together; filters read the paired I/Q registers.
// - rising write strobe captures the bus word into an input register.
// - select high steers the word to I, low to Q; host keeps select matched.
// - reset/sleep held four sample clocks or more puts the device to sleep.
// - reset/sleep shorter than four clocks only resets the input interface.
// - straight binary codes; all ones full scale on true output, zeros on complement.
// - interface splits the stream and keeps each I word paired with its Q word.
// - filter clock is sample clock halved; two paths picked on opposite phases.
// - each channel has an identical symmetric 43-tap half-band interpolator.
// - data to output latency is 55 clocks for I and 56 for Q.
package dac_pkg;
    localparam int DATA_W = 10;
    localparam int TAP_HIST = 22;
    localparam int COEF_PAIRS = 11;
    localparam int CENTER_TAP = 10;
    localparam int SCALE_SHIFT = 11;
    localparam logic [COEF_PAIRS-1:0][11:0] COEFS = {
        12'h4f0, 12'he70, 12'h0d8, 12'hf7d, 12'h051, 12'hfce,
        12'h01d, 12'hff0, 12'h008, 12'hffd, 12'h001};
    localparam logic signed [11:0] COEF_CENTER = 12'sh7ce;
    localparam logic [9:0] MSB_FLIP = 10'h200;
    localparam logic [9:0] CODE_RST = 10'h200;
    localparam logic [2:0] SLEEP_CYC = 3'h4;
    localparam int LAT_I_CYC = 55;
    localparam int LAT_Q_CYC = 56;
    localparam int CORE_CYC = 24;
    localparam int PAD_I = LAT_I_CYC - CORE_CYC;
    localparam int PAD_Q = LAT_Q_CYC - CORE_CYC;
    typedef enum logic [0:0] {
        PAIR_WAIT_I = 1'b0,
        PAIR_HAVE_I = 1'b1
    } pair_state_t;
endpackage

// [hdl/delay_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module delay_mem #(
    parameter int DEPTH = 31
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // data
    input wire logic [9:0] wr_data,
    output logic [9:0] rd_data
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][9:0] words;
        logic [PTR_W-1:0] ptr;
        logic [9:0] rd;
    } mem_state_t;

    mem_state_t st_r, st_nxt;

    // ring buffer: read old word, then overwrite it
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd = st_r.words[st_r.ptr];
        st_nxt.words[st_r.ptr] = wr_data;
        if (st_r.ptr == PTR_W'(DEPTH - 1)) begin
            st_nxt.ptr = '0;
        end else begin
            st_nxt.ptr = st_r.ptr + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data = st_r.rd;
endmodule
`default_nettype wire

// [hdl/dual_dac_input.sv]
`timescale 1ns/10ps
`default_nettype none
module dual_dac_input (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // parallel input bus
    input wire logic input_bit_msb,
    input wire logic [7:0] input_bits_middle,
    input wire logic input_bit_lsb,
    input wire logic write_strobe,
    input wire logic channel_select,
    // combined reset and power-down
    input wire logic reset_sleep,
    // converter codes
    output logic [dac_pkg::DATA_W-1:0] i_true_current_out,
    output logic [dac_pkg::DATA_W-1:0] i_complement_current_out,
    output logic [dac_pkg::DATA_W-1:0] q_true_current_out,
    output logic [dac_pkg::DATA_W-1:0] q_complement_current_out,
    output logic powered_down
);
    import dac_pkg::*;

    typedef struct packed {
        logic write_prev;
        logic [2:0] hold_cnt;
        logic asleep;
        pair_state_t pstate;
        logic [9:0] i_in;
        logic [9:0] q_in;
        logic [9:0] i_hold;
        logic [9:0] i_pair;
        logic [9:0] q_pair;
        logic phase;
        logic [1:0][TAP_HIST-1:0][9:0] taps;
        logic [1:0][9:0] filt;
        logic [1:0][9:0] code;
        logic [1:0][9:0] comp;
    } state_t;

    state_t st_r, st_nxt;
    logic [9:0] word;
    logic strobe_rise;
    logic [1:0][9:0] pair_signed;
    logic [1:0][9:0] branch_even;
    logic [1:0][9:0] branch_odd;
    logic [1:0][9:0] delayed;
    logic signed [10:0] psum [2][COEF_PAIRS];
    logic signed [22:0] prod [2][COEF_PAIRS];
    logic signed [22:0] cprod [2];

    // ------------------------------------------------------------
    // input capture
    // ------------------------------------------------------------
    assign word = {input_bit_msb, input_bits_middle, input_bit_lsb};
    assign strobe_rise = write_strobe & ~st_r.write_prev;
    assign pair_signed[0] = st_r.i_pair ^ MSB_FLIP;
    assign pair_signed[1] = st_r.q_pair ^ MSB_FLIP;

    function automatic logic [9:0] sat10(input logic signed [26:0] v);
        logic signed [26:0] s;
        s = v >>> SCALE_SHIFT;
        if (s > 27'sd511) begin
            sat10 = 10'h1ff;
        end else if (s < -27'sd512) begin
            sat10 = 10'h200;
        end else begin
            sat10 = s[9:0];
        end
    endfunction

    // ------------------------------------------------------------
    // half-band interpolators, one per channel
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        for (genvar j = 0; j < COEF_PAIRS; j++) begin : g_tap
            // symmetric pair shares one multiply
            assign psum[ch][j] = 11'($signed(st_r.taps[ch][j])) +
                11'($signed(st_r.taps[ch][TAP_HIST-1-j]));
            assign prod[ch][j] = psum[ch][j] * $signed(COEFS[j]);
        end
        assign cprod[ch] = $signed(st_r.taps[ch][CENTER_TAP]) *
            COEF_CENTER;
        assign branch_odd[ch] = sat10(27'(cprod[ch]));
        delay_mem #(
            .DEPTH(ch == 0 ? PAD_I : PAD_Q)
        ) u_delay (
            .clock(clock),
            .rst(rst),
            .wr_data(st_r.filt[ch]),
            .rd_data(delayed[ch])
        );
    end

    always_comb begin
        logic signed [26:0] acc;
        acc = '0;
        for (int ch = 0; ch < 2; ch++) begin
            acc = '0;
            for (int j = 0; j < COEF_PAIRS; j++) begin
                acc = acc + 27'(prod[ch][j]);
            end
            branch_even[ch] = sat10(acc);
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.write_prev = write_strobe;
        st_nxt.phase = ~st_r.phase;
        if (reset_sleep) begin
            // writes ignored and pairing held at start while asserted
            st_nxt.pstate = PAIR_WAIT_I;
            st_nxt.i_hold = '0;
            if (st_r.hold_cnt != SLEEP_CYC) begin
                st_nxt.hold_cnt = st_r.hold_cnt + 3'h1;
            end
            if (st_r.hold_cnt == SLEEP_CYC - 3'h1) begin
                st_nxt.asleep = 1'b1;
            end
        end else begin
            st_nxt.hold_cnt = '0;
            st_nxt.asleep = 1'b0;
            if (strobe_rise) begin
                if (channel_select) begin
                    st_nxt.i_in = word;
                    st_nxt.i_hold = word;
                    st_nxt.pstate = PAIR_HAVE_I;
                end else begin
                    st_nxt.q_in = word;
                    if (st_r.pstate == PAIR_HAVE_I) begin
                        st_nxt.i_pair = st_r.i_hold;
                        st_nxt.q_pair = word;
                        st_nxt.pstate = PAIR_WAIT_I;
                    end
                end
            end
        end
        if (!st_r.asleep) begin
            for (int ch = 0; ch < 2; ch++) begin
                if (!st_r.phase) begin
                    st_nxt.taps[ch] = {st_r.taps[ch][TAP_HIST-2:0],
                        pair_signed[ch]};
                    st_nxt.filt[ch] = branch_even[ch];
                end else begin
                    st_nxt.filt[ch] = branch_odd[ch];
                end
                st_nxt.code[ch] = delayed[ch] ^ MSB_FLIP;
                st_nxt.comp[ch] = ~(delayed[ch] ^ MSB_FLIP);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '0;
            // idle pair is mid-scale so an empty filter stays at zero
            st_r.i_pair <= CODE_RST;
            st_r.q_pair <= CODE_RST;
            st_r.code <= {CODE_RST, CODE_RST};
            st_r.comp <= {~CODE_RST, ~CODE_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign i_true_current_out = st_r.code[0];
    assign i_complement_current_out = st_r.comp[0];
    assign q_true_current_out = st_r.code[1];
    assign q_complement_current_out = st_r.comp[1];
    assign powered_down = st_r.asleep;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence long_hold_s;
        !reset_sleep ##1 reset_sleep [*4];
    endsequence
    sequence short_pulse_s;
        !reset_sleep ##1 reset_sleep [*3] ##1 !reset_sleep;
    endsequence
    sequence q_completes_s;
        strobe_rise && !channel_select && !reset_sleep &&
            st_r.pstate == PAIR_HAVE_I;
    endsequence

    sleep_entry_a: assert property (long_hold_s |=> powered_down)
        else $error("sleep not entered after four held cycles");
    short_pulse_a: assert property (short_pulse_s |=> !powered_down)
        else $error("short reset pulse caused power down");
    pair_restart_a: assert property (
        $fell(reset_sleep) |-> st_r.pstate == PAIR_WAIT_I)
        else $error("pairing not at start after reset pulse");
    i_capture_a: assert property (
        strobe_rise && channel_select && !reset_sleep
        |=> st_r.i_in == $past(word))
        else $error("I word not captured on strobe rise");
    q_steer_a: assert property (
        strobe_rise && !channel_select && !reset_sleep
        |=> st_r.q_in == $past(word) && $stable(st_r.i_in))
        else $error("Q word misrouted");
    pair_form_a: assert property (
        q_completes_s |=> st_r.q_pair == $past(word) &&
            st_r.i_pair == $past(st_r.i_hold))
        else $error("I and Q words not paired");
    filter_read_a: assert property (
        !st_r.phase && !powered_down
        |=> st_r.taps[1][0] == $past(pair_signed[1]) ##1
            $stable(st_r.taps[1]))
        else $error("filter did not read input on its phase");
    sleep_freeze_a: assert property (
        powered_down |=> $stable(i_true_current_out) &&
            $stable(q_true_current_out))
        else $error("outputs changed while asleep");
    complement_a: assert property (
        i_complement_current_out == ~i_true_current_out &&
        q_complement_current_out == ~q_true_current_out)
        else $error("complement output not inverse of true output");
    i_latency_a: assert property (
        !$past(powered_down) && !$past(rst, PAD_I + 2)
        |-> i_true_current_out ==
            ($past(st_r.filt[0], PAD_I + 2) ^ MSB_FLIP))
        else $error("I path delay wrong");
    q_latency_a: assert property (
        !$past(powered_down) && !$past(rst, PAD_Q + 2)
        |-> q_true_current_out ==
            ($past(st_r.filt[1], PAD_Q + 2) ^ MSB_FLIP))
        else $error("Q path delay wrong");
endmodule
`default_nettype wire

// [dv/iq_source.sv]
`timescale 1ns/10ps
`default_nettype none
module iq_source (
    // clock
    input wire logic clock,
    // interleaved word bus
    output logic input_bit_msb,
    output logic [7:0] input_bits_middle,
    output logic input_bit_lsb,
    output logic write_strobe,
    output logic channel_select,
    // combined reset and power-down
    output logic reset_sleep
);
    logic [9:0] bus_r;

    assign {input_bit_msb, input_bits_middle, input_bit_lsb} = bus_r;

    initial begin
        bus_r = 10'h000;
        write_strobe = 1'b0;
        channel_select = 1'b0;
        reset_sleep = 1'b0;
    end

    // ------------------------------------------------------------------
    // word transfers
    // ------------------------------------------------------------------
    // released bus shows the inverse so stale data never passes
    task automatic put_word(input logic [9:0] w, input logic sel);
        @(posedge clock);
        #1;
        bus_r = w;
        channel_select = sel;
        write_strobe = 1'b1;
        @(posedge clock);
        #1;
        write_strobe = 1'b0;
        bus_r = ~w;
        channel_select = ~sel;
    endtask

    task automatic put_pair(input logic [9:0] iw, input logic [9:0] qw);
        put_word(iw, 1'b1);
        put_word(qw, 1'b0);
    endtask

    // high for n sampled edges, driven active high
    task automatic hold_sleep(input int n);
        @(posedge clock);
        #1;
        reset_sleep = 1'b1;
        repeat (n) @(posedge clock);
        #1;
        reset_sleep = 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/test_dual_dac_input.sv]
`timescale 1ns/10ps
`default_nettype none
module test_dual_dac_input;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic msb, lsb, strobe, sel, rs, pd;
    logic [7:0] mid;
    logic [9:0] i_t, i_c, q_t, q_c;
    int err_count = 0;
    int checked = 0;

    always #5 clock = ~clock;

    iq_source i_src (.clock(clock), .input_bit_msb(msb),
        .input_bits_middle(mid), .input_bit_lsb(lsb),
        .write_strobe(strobe), .channel_select(sel), .reset_sleep(rs));

    dual_dac_input i_dut (.clock(clock), .rst(rst), .input_bit_msb(msb),
        .input_bits_middle(mid), .input_bit_lsb(lsb), .write_strobe(strobe),
        .channel_select(sel), .reset_sleep(rs),
        .i_true_current_out(i_t), .i_complement_current_out(i_c),
        .q_true_current_out(q_t), .q_complement_current_out(q_c),
        .powered_down(pd));

    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic check_val(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic reset_values();
        check_val(i_t, 10'h200);
        check_val(q_c, 10'h1ff);
        check_val({9'h000, pd}, 10'h000);
        repeat (60) @(posedge clock);
        #1;
        check_val(i_t, 10'h200);
        check_val(q_t, 10'h200);
    endtask

    // single step into both channels; q must follow i by one clock
    task automatic step_latency();
        int ti;
        int tq;
        ti = -1;
        tq = -1;
        i_src.put_pair(10'h3ff, 10'h3ff);
        for (int n = 0; n < 200; n++) begin
            @(posedge clock);
            #1;
            if (ti < 0 && i_t !== 10'h200) ti = n;
            if (tq < 0 && q_t !== 10'h200) tq = n;
        end
        if (ti < 0 || tq < 0) begin
            err_count++;
            $display("[FAIL] %0t no output step seen", $time);
            wrap_up();
        end
        check_val(10'(tq - ti), 10'h001);
        check_val(10'(ti < 56), 10'h001);
        check_val(10'(tq > 0), 10'h001);
    endtask

    // steady stream, then output codes inside the given windows
    task automatic dc_stream(input logic [9:0] iw, input logic [9:0] qw,
        input logic [9:0] ilo, input logic [9:0] ihi,
        input logic [9:0] qlo, input logic [9:0] qhi);
        repeat (40) i_src.put_pair(iw, qw);
        repeat (4) begin
            @(posedge clock);
            #1;
            check_val(10'(i_t >= ilo && i_t <= ihi), 10'h001);
            check_val(10'(q_t >= qlo && q_t <= qhi), 10'h001);
            check_val(i_c, ~i_t);
            check_val(q_c, ~q_t);
        end
    endtask

    // short pulse between I and Q drops the half-made pair
    task automatic pair_restart();
        i_src.put_word(10'h3ff, 1'b1);
        i_src.hold_sleep(2);
        i_src.put_word(10'h3ff, 1'b0);
        repeat (100) @(posedge clock);
        #1;
        check_val(10'(i_t >= 10'h1f0 && i_t <= 10'h210), 10'h001);
        check_val(10'(q_t <= 10'h030), 10'h001);
        check_val({9'h000, pd}, 10'h000);
    endtask

    task automatic sleep_modes();
        i_src.hold_sleep(3);
        check_val({9'h000, pd}, 10'h000);
        repeat (3) @(posedge clock);
        #1;
        check_val({9'h000, pd}, 10'h000);
        i_src.hold_sleep(4);
        check_val({9'h000, pd}, 10'h001);
        @(posedge clock);
        #1;
        check_val({9'h000, pd}, 10'h000);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        #1;
        rst = 1'b0;
        reset_values();
        step_latency();
        dc_stream(10'h3ff, 10'h000, 10'h3d0, 10'h3ff, 10'h000, 10'h030);
        dc_stream(10'h200, 10'h001, 10'h1f0, 10'h210, 10'h000, 10'h030);
        pair_restart();
        sleep_modes();
        wrap_up();
    end
endmodule
`default_nettype wire
